// >>> pkg/csd_defines.svh
`ifndef CSD_DEFINES_SVH
`define CSD_DEFINES_SVH
// ****************************************
// register map, byte offsets on the bus
// ****************************************
`define CSD_OFF_INSTR 8'h00
`define CSD_OFF_CTRL 8'h04
`define CSD_OFF_GO 8'h08
`define CSD_OFF_STATUS 8'h0c
`define CSD_OFF_MASK 8'h10
`define CSD_OFF_FLAGS 8'h14
`define CSD_OFF_IMM 8'h18
`define CSD_OFF_SCTRL 8'h1c
`define CSD_OFF_GPR 8'h40
`define CSD_OFF_GPR_END 8'h7c
// ****************************************
// field positions
// ****************************************
`define CSD_CTRL_COND 0
`define CSD_CTRL_INBLK 1
`define CSD_CTRL_PRIV 2
`define CSD_CTRL_WIDE 3
`define CSD_CTRL_CARRY 4
`define CSD_CTRL_W 5
`define CSD_ST_DONE 0
`define CSD_ST_UFAULT 1
`define CSD_ST_UNPRED 2
`define CSD_ST_DENY 3
`define CSD_ST_W 4
`define CSD_SCTRL_W 2
// ****************************************
// selectors, register numbers, reset value
// ****************************************
`define CSD_SEL_FLAGS 8'h00
`define CSD_SEL_CONTROL 8'h14
`define CSD_REG_SP 4'hd
`define CSD_REG_PC 4'hf
`define CSD_RST_WORD 32'h0000_0000
// ****************************************
// encoding masks and match values
// ****************************************
`define CSD_M_CP_SINGLE 32'hef10_0010
`define CSD_V_CP_SINGLE 32'hee10_0010
`define CSD_M_CP_DOUBLE 32'heff0_0000
`define CSD_V_CP_DOUBLE 32'hec50_0000
`define CSD_M_SPEC 32'hffe0_d000
`define CSD_V_SPEC_READ 32'hf3e0_8000
`define CSD_V_SPEC_WRITE 32'hf380_8000
`define CSD_M_MUL32 32'hfff0_f0f0
`define CSD_V_MUL32 32'hfb00_f000
`define CSD_M_NOT_IMM 32'hfbef_8000
`define CSD_V_NOT_IMM 32'hf06f_0000
`define CSD_M_MUL16 16'hffc0
`define CSD_V_MUL16 16'h4340
`endif

// >>> pkg/csd_pkg.sv
package csd_pkg;
  typedef enum logic [2:0] {
    OP_NONE = 3'b000,
    OP_CP_SINGLE = 3'b001,
    OP_CP_DOUBLE = 3'b010,
    OP_SPEC_READ = 3'b011,
    OP_SPEC_WRITE = 3'b100,
    OP_MUL32 = 3'b101,
    OP_MUL16 = 3'b110,
    OP_NOT_IMM = 3'b111
  } csd_op_t;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_EXEC = 2'b01,
    ST_CP_WAIT = 2'b10
  } csd_state_t;
endpackage : csd_pkg

// >>> pkg/csd_dec_if.sv
`timescale 1ns/10ps
interface csd_dec_if;
  import csd_pkg::*;
  logic [31:0] instr;
  logic wide;
  csd_op_t op;
  logic [3:0] first_dest_field;
  logic [3:0] second_dest_field;
  logic [3:0] operand_a_field;
  logic [3:0] operand_b_field;
  logic [3:0] cop_num;
  logic [3:0] cop_reg_first;
  logic [3:0] cop_reg_extra;
  logic [3:0] primary_subop;
  logic [2:0] secondary_subop;
  logic [7:0] special_reg_select;
  logic alt_form;
  logic set_s;
  logic unpred;
  modport dec (input instr, wide, output op, first_dest_field, second_dest_field,
    operand_a_field, operand_b_field, cop_num, cop_reg_first, cop_reg_extra,
    primary_subop, secondary_subop, special_reg_select, alt_form, set_s, unpred);
  modport core (output instr, wide, input op, first_dest_field, second_dest_field,
    operand_a_field, operand_b_field, cop_num, cop_reg_first, cop_reg_extra,
    primary_subop, secondary_subop, special_reg_select, alt_form, set_s, unpred);
endinterface : csd_dec_if

// >>> logic/csd_decode.sv
`timescale 1ns/10ps
`include "csd_defines.svh"
module csd_decode (
  csd_dec_if.dec dif
);
  import csd_pkg::*;
  logic [3:0] d;
  logic [3:0] d2;
  always_comb
  begin
    dif.op = OP_NONE;
    dif.first_dest_field = dif.instr[15:12];
    dif.second_dest_field = dif.instr[19:16];
    dif.operand_a_field = dif.instr[19:16];
    dif.operand_b_field = dif.instr[3:0];
    dif.cop_num = dif.instr[11:8];
    dif.cop_reg_first = dif.instr[19:16];
    dif.cop_reg_extra = dif.instr[3:0];
    dif.primary_subop = {1'b0, dif.instr[23:21]};
    dif.secondary_subop = dif.instr[7:5];
    dif.special_reg_select = dif.instr[7:0];
    dif.alt_form = dif.instr[28];
    dif.set_s = dif.instr[20];
    dif.unpred = 1'b0;
    d = dif.instr[15:12];
    d2 = dif.instr[19:16];
    if (!dif.wide)
    begin
      if ((dif.instr[15:0] & `CSD_M_MUL16) == `CSD_V_MUL16)
      begin
        dif.op = OP_MUL16;
        dif.first_dest_field = {1'b0, dif.instr[2:0]};
        dif.operand_a_field = {1'b0, dif.instr[5:3]};
        dif.operand_b_field = {1'b0, dif.instr[2:0]};
      end
    end
    else if ((dif.instr & `CSD_M_CP_SINGLE) == `CSD_V_CP_SINGLE)
    begin
      // alt form differs only in bit 28, both decode here
      dif.op = OP_CP_SINGLE;
      // secondary subop is zero in the encoding when it was left out
      dif.unpred = (d == `CSD_REG_SP);
    end
    else if ((dif.instr & `CSD_M_CP_DOUBLE) == `CSD_V_CP_DOUBLE)
    begin
      dif.op = OP_CP_DOUBLE;
      dif.primary_subop = dif.instr[7:4];
      dif.second_dest_field = dif.instr[19:16];
      dif.unpred = (d == `CSD_REG_PC) || (d2 == `CSD_REG_PC) || (d == d2) ||
        (d == `CSD_REG_SP) || (d2 == `CSD_REG_SP);
    end
    else if ((dif.instr & `CSD_M_SPEC) == `CSD_V_SPEC_READ)
    begin
      dif.op = OP_SPEC_READ;
      dif.first_dest_field = dif.instr[11:8];
    end
    else if ((dif.instr & `CSD_M_SPEC) == `CSD_V_SPEC_WRITE)
      dif.op = OP_SPEC_WRITE;
    else if ((dif.instr & `CSD_M_MUL32) == `CSD_V_MUL32)
    begin
      dif.op = OP_MUL32;
      dif.first_dest_field = dif.instr[11:8];
      dif.unpred = (dif.instr[11:8] == `CSD_REG_SP) || (dif.instr[11:8] == `CSD_REG_PC) ||
        (d2 == `CSD_REG_SP) || (d2 == `CSD_REG_PC) ||
        (dif.instr[3:0] == `CSD_REG_SP) || (dif.instr[3:0] == `CSD_REG_PC);
    end
    else if ((dif.instr & `CSD_M_NOT_IMM) == `CSD_V_NOT_IMM)
    begin
      dif.op = OP_NOT_IMM;
      dif.first_dest_field = dif.instr[11:8];
      dif.unpred = (dif.instr[11:8] == `CSD_REG_SP) ||
        (dif.instr[11:8] == `CSD_REG_PC);
    end
  end
endmodule : csd_decode

// >>> logic/csd_core.sv
// Functional notes
// - unaccepted coprocessor read raises usage fault, no write
// - single read with destination 13 is unpredictable
// - destination fifteen loads flags from word top
// - otherwise whole word goes to register 0-14
// - two subop fields, missing second reads zero
// - plain and alternate forms both decode
// - coprocessor number passed with the instruction
// - double read writes first and second word in one cycle
// - double read: 15, 13 or equal destinations unpredictable
// - double read has 4-bit subop, one cop register
// - special read privileged except flags and control
// - special write privileged except flags selector
// - multiply keeps low 32 product bits only
// - short multiply sets flags outside block only
// - long multiply with 13 or 15 unpredictable
// - immediate not writes complement, optional flags
// - immediate not destination 13/15 unpredictable
`timescale 1ns/10ps
`include "csd_defines.svh"
module csd_core (
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  output logic [31:0] o_hrdata,
  output logic o_hreadyout,
  output logic o_hresp,
  output logic o_cp_req,
  output logic [3:0] o_cp_num,
  output logic [31:0] o_cp_instr,
  output logic o_cp_double,
  input wire logic i_cp_resp,
  input wire logic i_cp_accept,
  input wire logic [31:0] i_cp_word0,
  input wire logic [31:0] i_cp_word1,
  output logic o_irq
);
  import csd_pkg::*;
  // ****************************************
  // state
  // ****************************************
  csd_state_t state_reg;
  csd_state_t state_next;
  logic [31:0] instr_reg;
  logic [31:0] exec_instr_reg;
  logic exec_wide_reg;
  logic [`CSD_CTRL_W-1:0] ctrl_reg;
  logic [`CSD_ST_W-1:0] status_reg;
  logic [`CSD_ST_W-1:0] mask_reg;
  logic [`CSD_ST_W-1:0] ev_set;
  logic [`CSD_ST_W-1:0] st_clr;
  logic [3:0] flags_reg;
  logic [3:0] flags_next;
  logic flags_we;
  logic [31:0] imm_reg;
  logic [`CSD_SCTRL_W-1:0] sctrl_reg;
  logic [`CSD_SCTRL_W-1:0] sctrl_next;
  logic sctrl_we;
  logic [31:0] gpr_reg [0:14];
  logic wr_pend_reg;
  logic [7:0] wr_addr_reg;
  logic [31:0] rdata_reg;
  logic go_pulse;
  logic we0;
  logic we1;
  logic [3:0] idx0;
  logic [3:0] idx1;
  logic [31:0] val0;
  logic [31:0] val1;
  logic [31:0] opa;
  logic [31:0] opb;
  logic [63:0] prod_full;
  logic [31:0] prod_low;
  logic [31:0] not_imm;
  logic [3:0] cp_top;
  logic [7:0] ra;
  logic [3:0] ridx;
  csd_dec_if dif ();
  assign dif.instr = exec_instr_reg;
  assign dif.wide = exec_wide_reg;
  csd_decode u_decode (
    .dif(dif)
  );
  // ****************************************
  // bus slave: zero wait states, always okay
  // ****************************************
  assign o_hreadyout = 1'b1;
  assign o_hresp = 1'b0;
  assign o_hrdata = rdata_reg;
  assign ra = i_haddr[7:0];
  assign ridx = ra[5:2];
  always_ff @(posedge i_sys_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
    end
    else if (i_hready)
    begin
      wr_pend_reg <= i_hsel && i_htrans[1] && i_hwrite;
      wr_addr_reg <= ra;
    end
  end
  // read data is latched at the address phase, so it shows state as of that edge
  always_ff @(posedge i_sys_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      rdata_reg <= `CSD_RST_WORD;
    else if (i_hready && i_hsel && i_htrans[1] && !i_hwrite)
    begin
      if (ra >= `CSD_OFF_GPR && ra < `CSD_OFF_GPR_END && ra[1:0] == 2'b00)
        rdata_reg <= gpr_reg[ridx];
      else
        case (ra)
          `CSD_OFF_INSTR: rdata_reg <= instr_reg;
          `CSD_OFF_CTRL: rdata_reg <= {27'h0, ctrl_reg};
          `CSD_OFF_GO: rdata_reg <= {30'h0, state_reg};
          `CSD_OFF_STATUS: rdata_reg <= {28'h0, status_reg};
          `CSD_OFF_MASK: rdata_reg <= {28'h0, mask_reg};
          `CSD_OFF_FLAGS: rdata_reg <= {flags_reg, 28'h0};
          `CSD_OFF_IMM: rdata_reg <= imm_reg;
          `CSD_OFF_SCTRL: rdata_reg <= {30'h0, sctrl_reg};
          default: rdata_reg <= `CSD_RST_WORD;
        endcase
    end
  end
  assign go_pulse = wr_pend_reg && (wr_addr_reg == `CSD_OFF_GO) && i_hwdata[0] &&
    (state_reg == ST_IDLE);
  // ****************************************
  // software registers
  // ****************************************
  always_ff @(posedge i_sys_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      instr_reg <= `CSD_RST_WORD;
      ctrl_reg <= '0;
      mask_reg <= '0;
      imm_reg <= `CSD_RST_WORD;
    end
    else if (wr_pend_reg)
      case (wr_addr_reg)
        `CSD_OFF_INSTR: instr_reg <= i_hwdata;
        `CSD_OFF_CTRL: ctrl_reg <= i_hwdata[`CSD_CTRL_W-1:0];
        `CSD_OFF_MASK: mask_reg <= i_hwdata[`CSD_ST_W-1:0];
        `CSD_OFF_IMM: imm_reg <= i_hwdata;
        default: ;
      endcase
  end
  // the decoder sees a copy taken at start, so software may load the next word early
  always_ff @(posedge i_sys_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      exec_instr_reg <= `CSD_RST_WORD;
      exec_wide_reg <= 1'b0;
    end
    else if (go_pulse)
    begin
      exec_instr_reg <= instr_reg;
      exec_wide_reg <= ctrl_reg[`CSD_CTRL_WIDE];
    end
  end
  // ****************************************
  // execution
  // ****************************************
  assign opa = (dif.operand_a_field == `CSD_REG_PC) ? '0 : gpr_reg[dif.operand_a_field];
  assign opb = (dif.operand_b_field == `CSD_REG_PC) ? '0 : gpr_reg[dif.operand_b_field];
  assign prod_full = opa * opb;
  assign prod_low = prod_full[31:0];
  assign not_imm = ~imm_reg;
  assign cp_top = i_cp_word0[31:28];
  always_comb
  begin
    state_next = state_reg;
    ev_set = '0;
    we0 = 1'b0;
    we1 = 1'b0;
    idx0 = dif.first_dest_field;
    idx1 = dif.second_dest_field;
    val0 = prod_low;
    val1 = i_cp_word1;
    flags_we = 1'b0;
    flags_next = flags_reg;
    sctrl_we = 1'b0;
    sctrl_next = sctrl_reg;
    case (state_reg)
      ST_IDLE:
        if (go_pulse)
          state_next = ST_EXEC;
      ST_EXEC:
      begin
        state_next = ST_IDLE;
        ev_set[`CSD_ST_DONE] = 1'b1;
        if (!ctrl_reg[`CSD_CTRL_COND])
          ev_set = ev_set;
        else if (dif.unpred)
          ev_set[`CSD_ST_UNPRED] = 1'b1;
        else
          case (dif.op)
            OP_CP_SINGLE, OP_CP_DOUBLE:
            begin
              state_next = ST_CP_WAIT;
              ev_set[`CSD_ST_DONE] = 1'b0;
            end
            OP_SPEC_READ:
              if (dif.special_reg_select == `CSD_SEL_FLAGS)
              begin
                we0 = 1'b1;
                val0 = {flags_reg, 28'h0};
              end
              else if (dif.special_reg_select == `CSD_SEL_CONTROL)
              begin
                we0 = 1'b1;
                val0 = {30'h0, sctrl_reg};
              end
              else if (ctrl_reg[`CSD_CTRL_PRIV])
              begin
                we0 = 1'b1;
                val0 = `CSD_RST_WORD;
              end
              else
                ev_set[`CSD_ST_DENY] = 1'b1;
            OP_SPEC_WRITE:
              if (dif.special_reg_select == `CSD_SEL_FLAGS)
              begin
                flags_we = 1'b1;
                flags_next = opa[31:28];
              end
              else if (!ctrl_reg[`CSD_CTRL_PRIV])
                ev_set[`CSD_ST_DENY] = 1'b1;
              else if (dif.special_reg_select == `CSD_SEL_CONTROL)
              begin
                sctrl_we = 1'b1;
                sctrl_next = opa[`CSD_SCTRL_W-1:0];
              end
            OP_MUL32, OP_MUL16:
            begin
              we0 = 1'b1;
              if (dif.op == OP_MUL16 && !ctrl_reg[`CSD_CTRL_INBLK])
              begin
                flags_we = 1'b1;
                flags_next = {prod_low[31], prod_low == 32'h0, flags_reg[1:0]};
              end
            end
            OP_NOT_IMM:
            begin
              we0 = 1'b1;
              val0 = not_imm;
              if (dif.set_s)
              begin
                flags_we = 1'b1;
                flags_next = {not_imm[31], not_imm == 32'h0, ctrl_reg[`CSD_CTRL_CARRY],
                  flags_reg[0]};
              end
            end
            default:
              ev_set[`CSD_ST_UFAULT] = 1'b1;
          endcase
      end
      ST_CP_WAIT:
        if (i_cp_resp)
        begin
          state_next = ST_IDLE;
          ev_set[`CSD_ST_DONE] = 1'b1;
          if (!i_cp_accept)
            ev_set[`CSD_ST_UFAULT] = 1'b1;
          else if (dif.op == OP_CP_DOUBLE)
          begin
            we0 = 1'b1;
            we1 = 1'b1;
            val0 = i_cp_word0;
          end
          else if (dif.first_dest_field == `CSD_REG_PC)
          begin
            flags_we = 1'b1;
            flags_next = cp_top;
          end
          else
          begin
            we0 = 1'b1;
            val0 = i_cp_word0;
          end
        end
      default:
        state_next = ST_IDLE;
    endcase
  end
  always_ff @(posedge i_sys_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      state_reg <= ST_IDLE;
    else
      state_reg <= state_next;
  end
  // ****************************************
  // register file, flags, special control
  // ****************************************
  // execution writes win over a bus write to the same word in the same cycle
  always_ff @(posedge i_sys_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      for (int i = 0; i < 15; i++)
        gpr_reg[i] <= `CSD_RST_WORD;
    end
    else
    begin
      if (wr_pend_reg && wr_addr_reg >= `CSD_OFF_GPR && wr_addr_reg < `CSD_OFF_GPR_END)
        gpr_reg[wr_addr_reg[5:2]] <= i_hwdata;
      if (we1 && idx1 != `CSD_REG_PC)
        gpr_reg[idx1] <= val1;
      if (we0 && idx0 != `CSD_REG_PC)
        gpr_reg[idx0] <= val0;
    end
  end
  always_ff @(posedge i_sys_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      flags_reg <= 4'h0;
      sctrl_reg <= '0;
    end
    else
    begin
      if (flags_we)
        flags_reg <= flags_next;
      else if (wr_pend_reg && wr_addr_reg == `CSD_OFF_FLAGS)
        flags_reg <= i_hwdata[31:28];
      if (sctrl_we)
        sctrl_reg <= sctrl_next;
      else if (wr_pend_reg && wr_addr_reg == `CSD_OFF_SCTRL)
        sctrl_reg <= i_hwdata[`CSD_SCTRL_W-1:0];
    end
  end
  // ****************************************
  // status and interrupt, set beats clear
  // ****************************************
  assign st_clr = (wr_pend_reg && wr_addr_reg == `CSD_OFF_STATUS) ?
    i_hwdata[`CSD_ST_W-1:0] : '0;
  always_ff @(posedge i_sys_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      status_reg <= '0;
    else
      status_reg <= (status_reg & ~st_clr) | ev_set;
  end
  assign o_irq = |(status_reg & mask_reg);
  // ****************************************
  // coprocessor port
  // ****************************************
  assign o_cp_req = (state_reg == ST_CP_WAIT);
  assign o_cp_num = exec_instr_reg[11:8];
  assign o_cp_instr = exec_instr_reg;
  assign o_cp_double = (dif.op == OP_CP_DOUBLE);
  // ****************************************
  // checks
  // ****************************************
  a_fault_no_write: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    o_cp_req && i_cp_resp && !i_cp_accept |=> status_reg[`CSD_ST_UFAULT] && $stable(flags_reg))
    else $error("rejected coprocessor read did not fault cleanly");
  a_single_sp_unpred: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    state_reg == ST_EXEC && ctrl_reg[`CSD_CTRL_COND] && dif.op == OP_CP_SINGLE &&
    dif.first_dest_field == `CSD_REG_SP |=> status_reg[`CSD_ST_UNPRED] && !o_cp_req)
    else $error("destination 13 not flagged unpredictable");
  a_flags_from_cp: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    o_cp_req && i_cp_resp && i_cp_accept && dif.op == OP_CP_SINGLE &&
    dif.first_dest_field == `CSD_REG_PC |=> flags_reg == $past(cp_top))
    else $error("flags not loaded from word top");
  a_word_to_reg: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    o_cp_req && i_cp_resp && i_cp_accept && dif.op == OP_CP_SINGLE &&
    dif.first_dest_field != `CSD_REG_PC |=> gpr_reg[$past(idx0)] == $past(i_cp_word0))
    else $error("coprocessor word not written");
  a_cp_number: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    o_cp_req && !i_cp_resp |=> o_cp_req && $stable(o_cp_num) && o_cp_num == dif.cop_num)
    else $error("coprocessor number wrong");
  a_double_second: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    o_cp_req && i_cp_resp && i_cp_accept && dif.op == OP_CP_DOUBLE
    |=> gpr_reg[$past(idx1)] == $past(i_cp_word1) && gpr_reg[$past(idx0)] == $past(i_cp_word0))
    else $error("double read words misplaced");
  a_cond_quiet: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    state_reg == ST_EXEC && !ctrl_reg[`CSD_CTRL_COND] |=> state_reg == ST_IDLE &&
    $stable(flags_reg) && !$rose(status_reg[`CSD_ST_UFAULT]) && !o_cp_req)
    else $error("failed condition had an effect");
  a_mul_flags: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    state_reg == ST_EXEC && ctrl_reg[`CSD_CTRL_COND] && !dif.unpred && dif.op == OP_MUL32
    |=> $stable(flags_reg))
    else $error("long multiply changed flags");
  a_not_value: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    state_reg == ST_EXEC && ctrl_reg[`CSD_CTRL_COND] && !dif.unpred && dif.op == OP_NOT_IMM
    |=> gpr_reg[$past(idx0)] == ~$past(imm_reg) && flags_reg[0] == $past(flags_reg[0]))
    else $error("immediate not result wrong");
endmodule : csd_core

// >>> test/csd_cop_model.sv
`timescale 1ns/10ps
module csd_cop_model (
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic i_req,
  input wire logic [3:0] i_num,
  input wire logic [15:0] i_accept_map,
  input wire logic [1:0] i_delay,
  input wire logic [31:0] i_w0,
  input wire logic [31:0] i_w1,
  output logic o_resp,
  output logic o_accept,
  output logic [31:0] o_word0,
  output logic [31:0] o_word1
);
  logic [1:0] cnt_reg;
  // ****************************************
  // answer after a programmable wait
  // ****************************************
  // while no request is pending the lines flip every cycle so stale data never looks valid
  always_ff @(posedge i_sys_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      cnt_reg <= 2'h0;
      o_resp <= 1'b0;
      o_accept <= 1'b0;
      o_word0 <= 32'h0;
      o_word1 <= 32'h0;
    end
    else
    begin
      o_resp <= 1'b0;
      if (i_req && !o_resp && cnt_reg == i_delay)
      begin
        o_resp <= 1'b1;
        o_accept <= i_accept_map[i_num];
        o_word0 <= i_w0;
        o_word1 <= i_w1;
        cnt_reg <= 2'h0;
      end
      else if (i_req && !o_resp)
        cnt_reg <= cnt_reg + 2'h1;
      else if (!o_resp)
      begin
        o_accept <= ~o_accept;
        o_word0 <= ~o_word0;
        o_word1 <= ~o_word1;
      end
    end
  end
endmodule : csd_cop_model

// >>> test/tb_top.sv
`timescale 1ns/10ps
`include "csd_defines.svh"
`define CHK(nm, ex, gt) begin n_tests++; if ((gt) !== (ex)) begin errors++; $display("[ERR] %s exp %h got %h", nm, ex, gt); end end
module tb_top;
  import csd_pkg::*;
  logic i_sys_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic hsel = 1'b0, hwrite = 1'b0, hready, hresp, req, dbl, resp, acc, irq;
  logic [1:0] htrans = 2'b00, dly = 2'h0;
  logic [3:0] num;
  logic [15:0] amap = 16'hffff;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, mw0 = 32'h0, mw1 = 32'h0;
  logic [31:0] hrdata, cins, w0, w1, sd, ins, d;
  logic [31:0] g [0:14];
  logic [3:0] fl, t, t2, rn;
  int errors = 0, n_tests = 0, cyc = 0;
  csd_core csd_core_i (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_hsel(hsel),
    .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2),
    .i_hwdata(hwdata), .i_hready(hready), .o_hrdata(hrdata), .o_hreadyout(hready),
    .o_hresp(hresp), .o_cp_req(req), .o_cp_num(num), .o_cp_instr(cins),
    .o_cp_double(dbl), .i_cp_resp(resp), .i_cp_accept(acc), .i_cp_word0(w0),
    .i_cp_word1(w1), .o_irq(irq));
  csd_cop_model csd_cop_model_i (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_req(req),
    .i_num(num), .i_accept_map(amap), .i_delay(dly), .i_w0(mw0), .i_w1(mw1),
    .o_resp(resp), .o_accept(acc), .o_word0(w0), .o_word1(w1));
  always #12.5 i_sys_clk = ~i_sys_clk;
  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    logic [31:0] r;
    r = s;
    for (int k = 0; k < 32; k++) r = {r[30:0], r[31] ^ r[21] ^ r[1] ^ r[0]};
    return r;
  endfunction : lfsr
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] v);
    @(posedge i_sys_clk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= {24'h0, a};
    @(posedge i_sys_clk);
    while (hready !== 1'b1) @(posedge i_sys_clk);
    htrans <= 2'b00;
    hwdata <= v;
    @(posedge i_sys_clk);
    while (hready !== 1'b1) @(posedge i_sys_clk);
    d = hrdata;
  endtask : ahb
  task automatic nw();
    sd = lfsr(sd);
    mw0 <= sd;
    dly <= sd[1:0];
    sd = lfsr(sd);
    mw1 <= sd;
    sd = lfsr(sd);
  endtask : nw
  // ef holds deny, unpredictable and fault bits; done is expected every time
  task automatic op(input logic [31:0] i, input logic [4:0] ct, input logic [2:0] ef);
    ahb(1'b1, `CSD_OFF_STATUS, 32'hf);
    ahb(1'b1, `CSD_OFF_INSTR, i);
    ahb(1'b1, `CSD_OFF_CTRL, {27'h0, ct});
    ahb(1'b1, `CSD_OFF_GO, 32'h1);
    d = 32'h1;
    for (int k = 0; k < 40 && d[1:0] !== 2'b00; k++) ahb(1'b0, `CSD_OFF_GO, 32'h0);
    ahb(1'b0, `CSD_OFF_STATUS, 32'h0);
    `CHK("status", {ef, 1'b1}, d[3:0])
    $display("test %h done", i);
  endtask : op
  task automatic cg(input logic [3:0] i);
    ahb(1'b0, `CSD_OFF_GPR + {i, 2'b00}, 32'h0);
    `CHK("gpr", g[i], d)
  endtask : cg
  task automatic cf();
    ahb(1'b0, `CSD_OFF_FLAGS, 32'h0);
    `CHK("flags", fl, d[31:28])
  endtask : cf
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : report_and_stop
  // hang guard, well above the thousand or so cycles the sequence needs
  always @(posedge i_sys_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      errors++;
      report_and_stop();
    end
  end
  // ****************************************
  // main sequence
  // ****************************************
  initial
  begin
    sd = 32'd1878;
    fl = 4'h0;
    repeat (12) @(posedge i_sys_clk);
    i_rst_n <= 1'b1;
    ahb(1'b0, `CSD_OFF_STATUS, 32'h0);
    `CHK("st_rst", 32'h0, d)
    cf();
    ahb(1'b0, `CSD_OFF_GPR_END, 32'h0);
    `CHK("unmapped", 32'h0, d)
    ahb(1'b1, `CSD_OFF_SCTRL, 32'h2);
    for (int i = 0; i < 15; i++)
    begin
      sd = lfsr(sd);
      g[i] = sd;
      ahb(1'b1, `CSD_OFF_GPR + 8'(4 * i), sd);
    end
    for (int a = 0; a < 2; a++)
    begin
      nw();
      t = 4'(sd[3:0] % 13);
      ins = {3'h7, a[0], 8'he1, sd[7:4], t, sd[11:8], a[0] ? sd[14:12] : 3'h0, 1'b1, sd[19:16]};
      op(ins, 5'h09, 3'b000);
      g[t] = mw0;
      cg(t);
      `CHK("cp_num", sd[11:8], num)
      `CHK("cp_instr", ins, cins)
      `CHK("cp_dbl", 1'b0, dbl)
      op({ins[31:16], 4'hf, ins[11:0]}, 5'h09, 3'b000);
      fl = mw0[31:28];
      cf();
      op({ins[31:16], 4'hd, ins[11:0]}, 5'h09, 3'b010);
      cg(4'hd);
      nw();
      t2 = 4'((t + 1) % 13);
      ins = {3'h7, a[0], 8'hc5, t2, t, sd[3:0], sd[7:4], sd[11:8]};
      op(ins, 5'h09, 3'b000);
      g[t] = mw0;
      g[t2] = mw1;
      cg(t);
      cg(t2);
      `CHK("cp_dbl", 1'b1, dbl)
      op({ins[31:20], t, ins[15:0]}, 5'h09, 3'b010);
      op({ins[31:20], 4'hf, ins[15:0]}, 5'h09, 3'b010);
      op({ins[31:16], 4'hd, ins[11:0]}, 5'h09, 3'b010);
    end
    amap <= 16'h0;
    op({16'hee10, 4'h3, 12'h510}, 5'h09, 3'b001);
    cg(4'h3);
    `CHK("irq_masked", 1'b0, irq)
    ahb(1'b1, `CSD_OFF_MASK, 32'h2);
    repeat (2) @(posedge i_sys_clk);
    `CHK("irq_on", 1'b1, irq)
    ahb(1'b1, `CSD_OFF_STATUS, 32'h2);
    repeat (2) @(posedge i_sys_clk);
    `CHK("irq_off", 1'b0, irq)
    ahb(1'b1, `CSD_OFF_MASK, 32'h0);
    amap <= 16'hffff;
    sd = lfsr(sd);
    t = 4'(sd[3:0] % 13);
    rn = 4'(sd[7:4] % 13);
    t2 = 4'(sd[11:8] % 13);
    op({12'hfb0, rn, 4'hf, t, 4'h0, t2}, 5'h08, 3'b000);
    cg(t);
    op({12'hfb0, rn, 4'hf, t, 4'h0, t2}, 5'h09, 3'b000);
    g[t] = g[rn] * g[t2];
    cg(t);
    cf();
    op({12'hfb0, rn, 8'hfd, 4'h0, t2}, 5'h09, 3'b010);
    op({12'hfb0, 4'hf, 4'hf, t, 4'h0, t2}, 5'h09, 3'b010);
    for (int b = 0; b < 2; b++)
    begin
      op({16'h0, 10'h10d, sd[14:12], sd[18:16]}, {3'h0, b[0], 1'b1}, 3'b000);
      g[sd[18:16]] = g[sd[14:12]] * g[sd[18:16]];
      if (b == 0) fl = {g[sd[18:16]][31], g[sd[18:16]] == 32'h0, fl[1:0]};
      cg(4'(sd[18:16]));
      cf();
    end
    for (int b = 0; b < 2; b++)
    begin
      ahb(1'b1, `CSD_OFF_IMM, b ? 32'hffff_ffff : sd);
      op({5'h1e, 1'b0, 5'h03, 1'b1, 8'hf0, t, 8'h00}, 5'h19, 3'b000);
      g[t] = b ? 32'h0 : ~sd;
      fl = {g[t][31], g[t] == 32'h0, 1'b1, fl[0]};
      cg(t);
      cf();
    end
    op({5'h1e, 1'b0, 5'h03, 1'b1, 8'hf0, 4'hf, 8'h00}, 5'h19, 3'b010);
    op({16'hf3ef, 4'h8, t, 8'h14}, 5'h09, 3'b000);
    g[t] = 32'h2;
    cg(t);
    op({16'hf3ef, 4'h8, t, 8'h08}, 5'h09, 3'b100);
    cg(t);
    op({16'hf3ef, 4'h8, t, 8'h08}, 5'h0d, 3'b000);
    g[t] = 32'h0;
    cg(t);
    op({12'hf38, rn, 8'h88, 8'h01}, 5'h09, 3'b100);
    cf();
    op({12'hf38, rn, 8'h88, 8'h00}, 5'h09, 3'b000);
    fl = g[rn][31:28];
    cf();
    op({16'hf3ef, 4'h8, t, 8'h00}, 5'h09, 3'b000);
    g[t] = {fl, 28'h0};
    cg(t);
    op({12'hf38, rn, 8'h88, 8'h14}, 5'h0d, 3'b000);
    op({16'hf3ef, 4'h8, t, 8'h14}, 5'h09, 3'b000);
    g[t] = {30'h0, g[rn][1:0]};
    cg(t);
    `CHK("hresp", 1'b0, hresp)
    report_and_stop();
  end
endmodule : tb_top
